// ===== rtl/bus_arbiter_cpu.sv
// processor end: input synchronisers, arbitration machine, bus error termination
`timescale 1ns/1ns
`default_nettype none
module bus_arbiter_cpu #(
    parameter bit THREE_WIRE = 1'b1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    arb_link_if.cpu               link,
    input  wire logic             i_cycle_req,
    input  wire logic             i_cycle_rmw,
    output logic                  o_cycle_busy,
    output logic [4:0]            o_bus_state,
    output logic                  o_three_state,
    output logic                  o_float_bus,
    output logic                  o_data_float,
    output logic                  o_bus_error,
    output logic                  o_exc_active,
    output logic                  o_stack_push,
    output logic [2:0]            o_stack_item,
    output logic                  o_vector_fetch,
    output logic [7:0]            o_vector_offset,
    output logic                  o_sync_reset,
    output logic                  o_sync_halt,
    output logic [2:0]            o_sync_ipl
);
    import arb_pkg::*;

    // ****************
    // synchronisers
    // ****************
    localparam int SW = 9;
    logic [SW-1:0] async_in;
    logic [SW-1:0] fall_r;
    logic [SW-1:0] sync_r;
    // bit order: request, grant ack, data ack, error, halt, priority, reset slot
    // reset slot unused, the block reset arrives already clocked
    assign async_in = {link.bus_request_in, link.grant_acknowledge, link.data_transfer_ack,
                       link.bus_error_in, link.halt_in, link.interrupt_priority_inputs, 1'b0};

    // falling edge capture, rising edge hand-off
    always_ff @(negedge i_clk) begin
        fall_r <= async_in;
    end
    always_ff @(posedge i_clk) begin
        sync_r <= fall_r;
    end

    wire req_s   = sync_r[8];
    wire ack_s   = THREE_WIRE ? sync_r[7] : 1'b0;
    wire data_transfer_ack_s = sync_r[6];
    wire bus_error_in_s  = sync_r[5];
    wire halt_s  = sync_r[4];
    assign o_sync_reset = 1'b0;
    assign o_sync_halt  = halt_s;
    assign o_sync_ipl   = sync_r[3:1];

    // ****************
    // bus cycle sequencer
    // ****************
    cyc_state_t cyc_r, cyc_nxt;
    logic [4:0] st_r;
    logic       acked_r;
    logic       ack_first_r;
    logic       err_data_transfer_ack_r;
    logic [2:0] item_r;
    logic       bus_owner_r;

    wire       in_s01    = (cyc_r == CYC_RUN) && (st_r <= BUS_S1);
    wire       rmw_write = i_cycle_rmw && (st_r >= BUS_S12);
    wire       wait_st   = rmw_write ? (st_r == BUS_S16) : (st_r == BUS_S4);
    wire       bus_error_in_ok   = bus_error_in_s && !halt_s && !ack_first_r;
    wire [4:0] err_end   = err_data_transfer_ack_r ? (rmw_write ? BUS_S19 : BUS_S7)
                                       : (rmw_write ? BUS_S21 : BUS_S9);
    wire [4:0] norm_end  = i_cycle_rmw ? BUS_S19 : BUS_S7;
    wire       can_start = bus_owner_r && i_cycle_req && !link.address_strobe;

    // ****************
    // termination decode
    // ****************
    // a wait state holds until either terminator is seen
    wire term_seen  = data_transfer_ack_s || bus_error_in_s;
    wire stall      = wait_st && !term_seen;
    // data ack alone in the wait state ends the cycle normally
    wire data_transfer_ack_take = wait_st && data_transfer_ack_s && !bus_error_in_s;
    // a recognised error, and whether data ack came with it
    wire bus_error_in_take  = wait_st && bus_error_in_ok;
    wire bus_error_in_data_transfer_ack = bus_error_in_take && data_transfer_ack_s;
    // write half of a locked cycle judges its own ack afresh
    wire write_half = i_cycle_rmw && (st_r == BUS_S12);
    wire err_done   = acked_r && (st_r == err_end);
    wire ok_done    = !acked_r && ack_first_r && (st_r == norm_end);
    wire stack_last = (item_r == (STACK_WORDS - 3'h1));

    // idle, numbered states, wait out the error, stack, fetch vector
    always_comb begin
        cyc_nxt = cyc_r;
        unique case (cyc_r)
            CYC_IDLE:   if (can_start) cyc_nxt = CYC_RUN;
            CYC_RUN:    if (err_done) cyc_nxt = CYC_ERRWT;
                        else if (ok_done) cyc_nxt = CYC_IDLE;
            CYC_ERRWT:  if (!bus_error_in_s) cyc_nxt = CYC_STACK;
            CYC_STACK:  if (stack_last) cyc_nxt = CYC_VECTOR;
            CYC_VECTOR: cyc_nxt = CYC_IDLE;
            default:    cyc_nxt = CYC_IDLE;
        endcase
    end

    // acked_r marks a recognised bus error; ack_first_r a data ack seen first
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cyc_r       <= CYC_IDLE;
            st_r        <= BUS_S0;
            acked_r     <= 1'b0;
            ack_first_r <= 1'b0;
            err_data_transfer_ack_r <= 1'b0;
            item_r      <= 3'h0;
        end else begin
            cyc_r <= cyc_nxt;
            if (cyc_r == CYC_IDLE) begin
                st_r        <= BUS_S0;
                acked_r     <= 1'b0;
                ack_first_r <= 1'b0;
                err_data_transfer_ack_r <= 1'b0;
                item_r      <= 3'h0;
            end else if (cyc_r == CYC_RUN) begin
                if (write_half) ack_first_r <= 1'b0;
                if (data_transfer_ack_take) ack_first_r <= 1'b1;
                if (bus_error_in_take) acked_r <= 1'b1;
                if (bus_error_in_data_transfer_ack) err_data_transfer_ack_r <= 1'b1;
                if (!stall && cyc_nxt == CYC_RUN) st_r <= st_r + 5'h01;
            end else if (cyc_r == CYC_STACK) begin
                item_r <= item_r + 3'h1;
            end
        end
    end

    // ****************
    // arbitration machine
    // ****************
    arb_state_t arb_r, arb_nxt;
    logic       late_r;

    // frozen in S0/S1 so a late request waits for the strobe
    always_comb begin
        arb_nxt = arb_r;
        if (!in_s01) begin
            unique case (arb_r)
                ARB_OWN:     if (req_s) arb_nxt = late_r ? ARB_WAIT2 : ARB_GRANT;
                ARB_WAIT2:   arb_nxt = ARB_GRANT;
                ARB_GRANT:   if (ack_s) arb_nxt = ARB_ACKED;
                             else if (!THREE_WIRE && !req_s) arb_nxt = ARB_OWN;
                ARB_ACKED:   if (!ack_s) arb_nxt = req_s ? ARB_GRANT : ARB_OWN;
                             else if (req_s) arb_nxt = ARB_RELEASE;
                ARB_RELEASE: arb_nxt = ack_s ? ARB_GRANT : (req_s ? ARB_GRANT : ARB_OWN);
                default:     arb_nxt = ARB_OWN;
            endcase
        end
    end

    // owner flag gates new processor cycles
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arb_r       <= ARB_OWN;
            late_r      <= 1'b0;
            bus_owner_r <= 1'b1;
        end else begin
            arb_r       <= arb_nxt;
            late_r      <= in_s01;
            bus_owner_r <= (arb_nxt == ARB_OWN) && !ack_s;
        end
    end

    // ****************
    // outputs
    // ****************
    // grant stands in both granting states
    wire grant_w = (arb_r == ARB_GRANT) || (arb_r == ARB_RELEASE);
    assign link.bus_grant_out = grant_w;
    // strobe held through both halves of a locked cycle, dropped at abort end
    assign link.address_strobe_cpu = (cyc_r == CYC_RUN) && (st_r >= BUS_S2) && !err_done;
    assign o_three_state   = (arb_r != ARB_OWN) && (cyc_r != CYC_RUN);
    assign o_float_bus     = o_three_state && !link.address_strobe;
    assign o_data_float    = o_float_bus || bus_error_in_s;
    assign o_cycle_busy    = (cyc_r != CYC_IDLE);
    assign o_bus_state     = st_r;

    // ****************
    // exception outputs
    // ****************
    assign o_bus_error     = (cyc_r == CYC_ERRWT);
    assign o_exc_active    = (cyc_r == CYC_STACK) || (cyc_r == CYC_VECTOR);
    assign o_stack_push    = (cyc_r == CYC_STACK);
    assign o_stack_item    = item_r;
    assign o_vector_fetch  = (cyc_r == CYC_VECTOR);
    assign o_vector_offset = BUS_ERROR_IN_VECTOR_OFFSET;
endmodule // bus_arbiter_cpu
`default_nettype wire

// ===== rtl/arb_pkg.sv
// constants and types shared by the processor-side arbiter and the external master
// Behaviour
// - master waits strobe, ack, grant-ack negated; here only with THREE_WIRE set
// - no takeover while address strobe asserted; here only with THREE_WIRE set
// - grant-ack held until cycles complete
// - master drops request after grant-ack
// - regrant pending request, no bus cycle first
// - inputs sampled falling, valid after rising
// - same synchroniser on reset, halt, ack, error, priority; here the reset slot is tied low and reset is not synchronised
// - state machine uses synchronised request, grant-ack
// - float buses when three-state and strobe negated
// - hold arbiter state in bus states 0/1
// - late request delays grant two edges
// - bus error needs error, no halt, no ack first
// - read/write error ends state 7 or 9
// - rmw write error ends state 19 or 21
// - data bus floats while bus error asserted
// - stack status, two-word pc, error info
// - fetch vector entry 2, offset 08
// - external timeout asserts bus error
// - two-wire mode grant-ack held inactive
// - two-wire: request held, grant drops on release
// - three-wire: grant drops after grant-ack
package arb_pkg;

    // ****************
    // bus state numbers
    // ****************
    localparam logic [4:0] BUS_S0  = 5'h00;
    localparam logic [4:0] BUS_S1  = 5'h01;
    localparam logic [4:0] BUS_S2  = 5'h02;
    localparam logic [4:0] BUS_S4  = 5'h04;
    localparam logic [4:0] BUS_S7  = 5'h07;
    localparam logic [4:0] BUS_S9  = 5'h09;
    localparam logic [4:0] BUS_S12 = 5'h0c;
    localparam logic [4:0] BUS_S16 = 5'h10;
    localparam logic [4:0] BUS_S19 = 5'h13;
    localparam logic [4:0] BUS_S21 = 5'h15;

    // ****************
    // exception, arbitration, master and reset figures
    // ****************
    localparam logic [7:0] BUS_ERROR_IN_VECTOR_NUM    = 8'h02;
    localparam logic [7:0] BUS_ERROR_IN_VECTOR_OFFSET = 8'h08;
    localparam logic [2:0] STACK_WORDS        = 3'h4;
    localparam logic [3:0] REGRANT_DELAY      = 4'h2;
    localparam logic [7:0] MASTER_CYCLES      = 8'h04;
    localparam logic [3:0] SYNC_RESET_VALUE   = 4'h0;

    typedef enum logic [2:0] {
        ARB_OWN     = 3'b000,
        ARB_GRANT   = 3'b001,
        ARB_ACKED   = 3'b010,
        ARB_RELEASE = 3'b011,
        ARB_WAIT2   = 3'b100
    } arb_state_t;

    typedef enum logic [2:0] {
        CYC_IDLE   = 3'b000,
        CYC_RUN    = 3'b001,
        CYC_ERRWT  = 3'b010,
        CYC_STACK  = 3'b011,
        CYC_VECTOR = 3'b100
    } cyc_state_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_REQ  = 2'b01,
        MST_OWN  = 2'b10,
        MST_DONE = 2'b11
    } mst_state_t;

endpackage

// ===== rtl/arb_link_if.sv
// interface carrying the arbitration and termination signals between the two ends
`timescale 1ns/1ns
`default_nettype none
interface arb_link_if;
    logic bus_request_in;
    logic bus_grant_out;
    logic grant_acknowledge;
    logic address_strobe_cpu;
    logic address_strobe_ext;
    logic address_strobe;
    logic data_transfer_ack;
    logic bus_error_in;
    logic halt_in;
    logic [2:0] interrupt_priority_inputs;

    assign address_strobe = address_strobe_cpu | address_strobe_ext;

    modport cpu (
        input  bus_request_in,
        input  grant_acknowledge,
        input  address_strobe,
        input  data_transfer_ack,
        input  bus_error_in,
        input  halt_in,
        input  interrupt_priority_inputs,
        output bus_grant_out,
        output address_strobe_cpu
    );

    modport ext (
        output bus_request_in,
        output grant_acknowledge,
        output address_strobe_ext,
        output data_transfer_ack,
        output bus_error_in,
        output halt_in,
        output interrupt_priority_inputs,
        input  bus_grant_out,
        input  address_strobe
    );
endinterface
`default_nettype wire

// ===== rtl/bus_master_ext.sv
// external end: requesting master with its own slave answer and error timeout
`timescale 1ns/1ns
`default_nettype none
module bus_master_ext #(
    parameter bit       THREE_WIRE = 1'b1,
    parameter int       TIMEOUT    = 16
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    arb_link_if.ext     link,
    input  wire logic   i_want_bus,
    input  wire logic   i_slave_ready,
    input  wire logic   i_halt,
    input  wire logic [2:0] i_ipl,
    output logic        o_owner,
    output logic        o_done
);
    import arb_pkg::*;

    mst_state_t st_r;
    logic [7:0] cnt_r;
    logic [7:0] tmo_r;

    wire free = !link.address_strobe && !link.data_transfer_ack
                && !link.grant_acknowledge;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r  <= MST_IDLE;
            cnt_r <= 8'h00;
        end else begin
            unique case (st_r)
                MST_IDLE: if (i_want_bus) st_r <= MST_REQ;
                MST_REQ:  if (link.bus_grant_out && (free || !THREE_WIRE)) st_r <= MST_OWN;
                MST_OWN:  if (cnt_r == MASTER_CYCLES) st_r <= MST_DONE;
                          else cnt_r <= cnt_r + 8'h01;
                MST_DONE: begin
                    cnt_r <= 8'h00;
                    if (!i_want_bus) st_r <= MST_IDLE;
                end
            endcase
        end
    end

    // timeout from strobe
    always_ff @(posedge i_clk) begin
        if (i_rst || !link.address_strobe) tmo_r <= 8'h00;
        else if (tmo_r != 8'(TIMEOUT)) tmo_r <= tmo_r + 8'h01;
    end

    assign link.bus_request_in = (st_r == MST_REQ) || (!THREE_WIRE && st_r == MST_OWN);
    assign link.grant_acknowledge = THREE_WIRE && (st_r == MST_OWN);
    assign link.address_strobe_ext = 1'b0;
    assign link.data_transfer_ack = link.address_strobe && i_slave_ready;
    assign link.bus_error_in = (tmo_r == 8'(TIMEOUT));
    assign link.halt_in = i_halt;
    assign link.interrupt_priority_inputs = i_ipl;
    assign o_owner = (st_r == MST_OWN);
    assign o_done  = (st_r == MST_DONE);
endmodule // bus_master_ext
`default_nettype wire

// ===== verif/arb_link_props.sv
// concurrent checks on the arbitration link between the two ends
`timescale 1ns/1ns
`default_nettype none
module arb_link_props (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       bus_request_in,
    input wire logic       bus_grant_out,
    input wire logic       grant_acknowledge,
    input wire logic       address_strobe_cpu,
    input wire logic       address_strobe_ext,
    input wire logic       address_strobe,
    input wire logic       data_transfer_ack
);
    // ****************
    // arbitration
    // ****************
    chk_ack_after_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(grant_acknowledge) |-> $past(!address_strobe && !data_transfer_ack))
        else $error("acknowledge taken while bus busy");
    chk_strobe_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
        !(address_strobe_cpu && address_strobe_ext))
        else $error("two strobe drivers at once");
    chk_cpu_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        grant_acknowledge && $past(grant_acknowledge) |-> !address_strobe_cpu)
        else $error("processor strobe while other owns bus");
    chk_ack_held: assert property (@(posedge i_clk) disable iff (i_rst)
        grant_acknowledge && address_strobe_ext |=> grant_acknowledge)
        else $error("acknowledge dropped mid cycle");
    chk_request_drops: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(grant_acknowledge) |-> ##[0:4] !bus_request_in)
        else $error("request kept after acknowledge");
    chk_grant_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(bus_grant_out) |-> $past(bus_request_in) || $past(bus_request_in, 2))
        else $error("grant without request");
    chk_grant_latency: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(bus_request_in) && !grant_acknowledge |-> ##[1:12] bus_grant_out)
        else $error("grant late");
    chk_grant_drops: assert property (@(posedge i_clk) disable iff (i_rst)
        grant_acknowledge && bus_grant_out |-> ##[1:6] !bus_grant_out)
        else $error("grant kept after acknowledge");
    chk_reset_idle: assert property (@(posedge i_clk)
        i_rst |=> !bus_grant_out)
        else $error("grant up after reset");
endmodule // arb_link_props
`default_nettype wire

// ===== verif/bus_mastership_and_error_unit_tb.sv
// self-checking bench joining processor end and external master
`timescale 1ns/1ns
`default_nettype none
module bus_mastership_and_error_unit_tb;
    import arb_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_cycle_req = 1'b0, i_cycle_rmw = 1'b0, i_want_bus = 1'b0;
    logic       i_slave_ready = 1'b1, i_halt = 1'b0;
    logic [2:0] i_ipl = 3'h0;
    logic       o_cycle_busy, o_three_state, o_float_bus, o_data_float, o_bus_error;
    logic       o_exc_active, o_stack_push, o_vector_fetch, o_sync_halt, o_owner, o_done;
    logic [4:0] o_bus_state;
    logic [2:0] o_stack_item, o_sync_ipl;
    logic [7:0] o_vector_offset;
    int         bad_count = 0;
    int         comparisons = 0;
    arb_link_if link ();
    bus_arbiter_cpu #(.THREE_WIRE(1'b1)) bus_arbiter_cpu_i (.i_clk(i_clk), .i_rst(i_rst),
        .link(link), .i_cycle_req(i_cycle_req), .i_cycle_rmw(i_cycle_rmw),
        .o_cycle_busy(o_cycle_busy), .o_bus_state(o_bus_state), .o_three_state(o_three_state),
        .o_float_bus(o_float_bus), .o_data_float(o_data_float), .o_bus_error(o_bus_error),
        .o_exc_active(o_exc_active), .o_stack_push(o_stack_push), .o_stack_item(o_stack_item),
        .o_vector_fetch(o_vector_fetch), .o_vector_offset(o_vector_offset),
        .o_sync_reset(), .o_sync_halt(o_sync_halt), .o_sync_ipl(o_sync_ipl));
    bus_master_ext #(.THREE_WIRE(1'b1), .TIMEOUT(4)) bus_master_ext_i (.i_clk(i_clk),
        .i_rst(i_rst), .link(link), .i_want_bus(i_want_bus), .i_slave_ready(i_slave_ready),
        .i_halt(i_halt), .i_ipl(i_ipl), .o_owner(o_owner), .o_done(o_done));
    arb_link_props arb_link_props_i (.i_clk(i_clk), .i_rst(i_rst),
        .bus_request_in(link.bus_request_in), .bus_grant_out(link.bus_grant_out),
        .grant_acknowledge(link.grant_acknowledge),
        .address_strobe_cpu(link.address_strobe_cpu),
        .address_strobe_ext(link.address_strobe_ext), .address_strobe(link.address_strobe),
        .data_transfer_ack(link.data_transfer_ack));
    always #5 i_clk = ~i_clk;
    // ****************
    // shared tasks
    // ****************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one processor cycle, slave answering or left to time out
    task run_cycle(input logic rmw, input logic rdy, input logic late, input logic [4:0] st,
                   input string nm);
        int n;
        int pushes;
        n = 0;
        pushes = 0;
        i_cycle_rmw = rmw;
        i_slave_ready = rdy | late;
        i_cycle_req = 1'b1;
        while (!o_cycle_busy && n < 50) begin @(negedge i_clk); n++; end
        i_cycle_req = 1'b0;
        while (o_cycle_busy && !o_bus_error && n < 100) begin
            @(negedge i_clk);
            n++;
            if (late && o_bus_state >= BUS_S12) i_slave_ready = 1'b0;
        end
        if (!rdy) begin
            check({3'h0, o_bus_state}, {3'h0, st});
            check({7'h0, o_data_float}, 8'h01);
            while (!o_vector_fetch && n < 300) begin
                pushes += int'(o_stack_push);
                @(negedge i_clk);
                n++;
            end
            check(8'(pushes), {5'h0, STACK_WORDS});
            check(o_vector_offset, BUS_ERROR_IN_VECTOR_OFFSET);
        end else begin
            check({7'h0, o_bus_error}, 8'h00);
        end
        check({7'h0, 1'(n < 300)}, 8'h01);
        i_slave_ready = 1'b1;
        i_cycle_rmw = 1'b0;
        repeat (8) @(negedge i_clk);
        $display("test %s done", nm);
    endtask
    // external master takes the bus and hands it back
    task take_bus;
        int n;
        n = 0;
        i_want_bus = 1'b1;
        while (!o_owner && n < 100) begin @(negedge i_clk); n++; end
        check({7'h0, o_three_state}, 8'h01);
        check({7'h0, o_float_bus}, 8'h01);
        while (!o_done && n < 200) begin @(negedge i_clk); n++; end
        i_want_bus = 1'b0;
        repeat (12) @(negedge i_clk);
        check({6'h0, o_three_state, link.bus_grant_out}, 8'h00);
        $display("test arbitration done");
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check({6'h0, o_three_state, link.bus_grant_out}, 8'h00);
        i_halt = 1'b1;
        i_ipl = 3'h5;
        repeat (3) @(negedge i_clk);
        check({4'h0, o_sync_halt, o_sync_ipl}, 8'h0d);
        i_halt = 1'b0;
        repeat (3) @(negedge i_clk);
        $display("test reset done");
        run_cycle(1'b0, 1'b1, 1'b0, BUS_S0, "normal");
        run_cycle(1'b0, 1'b0, 1'b0, BUS_S9, "error");
        run_cycle(1'b1, 1'b0, 1'b0, BUS_S9, "rmw read error");
        run_cycle(1'b1, 1'b0, 1'b1, BUS_S21, "rmw write error");
        take_bus();
        i_cycle_req = 1'b1;
        take_bus();
        i_cycle_req = 1'b0;
        run_cycle(1'b0, 1'b1, 1'b0, BUS_S0, "after handover");
        close_out();
    end
    initial begin
        #60000;
        bad_count++;
        close_out();
    end
endmodule // bus_mastership_and_error_unit_tb
`default_nettype wire
